// file: inc/twsc_defines.svh
`ifndef TWSC_DEFINES_SVH
`define TWSC_DEFINES_SVH

// Register byte addresses on the AXI4-Lite slave
`define TWSC_MODE_ADDR      4'h0
`define TWSC_START_ADDR     4'h4
`define TWSC_PORT_ADDR      4'h8
`define TWSC_PINS_ADDR      4'hC

// Mode register field positions
`define TWSC_CKSEL_LO_BIT   0
`define TWSC_CKSEL_HI_BIT   1
`define TWSC_SOEN_BIT       2
`define TWSC_TS_BIT         3

// Port control register field positions
`define TWSC_DIR_CLK_BIT    0
`define TWSC_DIR_DO_BIT     1
`define TWSC_DIR_DI_BIT     2
`define TWSC_LAT_CLK_BIT    4
`define TWSC_LAT_DO_BIT     5

// Reset values: initial status is internal clock, clock pin output high
`define TWSC_MODE_RESET     4'h1
`define TWSC_PORT_RESET     8'h11

// Clock rates in Hz, core clock 20 MHz
`define TWSC_MCLK_HZ        20000000
`define TWSC_F1_HZ          75000
`define TWSC_F2_HZ          150000
`define TWSC_F3_HZ          450000
// Half periods in core cycles, rounded down, so never longer than the exact time
`define TWSC_HALF1          (`TWSC_MCLK_HZ / (2 * `TWSC_F1_HZ))
`define TWSC_HALF2          (`TWSC_MCLK_HZ / (2 * `TWSC_F2_HZ))
`define TWSC_HALF3          (`TWSC_MCLK_HZ / (2 * `TWSC_F3_HZ))

// Shift clocks per transfer
`define TWSC_BITS           4'h8

`endif

// file: inc/twsc_pkg.sv
package twsc_pkg;

    // Clock select codes
    typedef enum logic [1:0] {
        TWSC_CK_EXT  = 2'b00,
        TWSC_CK_F75  = 2'b01,
        TWSC_CK_F150 = 2'b10,
        TWSC_CK_F450 = 2'b11
    } twsc_cksel_t;

    // One two-way pin: output, active low enable; the input is a separate port
    typedef struct packed {
        logic dout;
        logic oen_n;
    } twsc_pin_t;

endpackage : twsc_pkg

// file: rtl/twsc_serial_clock.sv
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "twsc_defines.svh"
// Notes on behaviour
// - Mode clock-select bits set internal frequency
// - Code 00 slave; others 75/150/450 kHz
// - Pin role needs mode and direction flag
// - Ext clock, input: wait GPI, else clock
// - Ext clock, output flag: plain output
// - Int clock, input flag: plain input
// - Int clock output held high during wait
// - Serial out needs enable and direction 1
// - Master emits clocks until counter reaches eight
// - Wait release from initial status starts clock
// - Writing start 0 forces wait, clears counter
// - Release while released changes nothing
// - Frequency change with release acts like start
// - Counter samples pin level, any source
// - Counter holds during wait
// - Counter not readable by software
// - Counter counts falling edges from zero
// - At eight, rising edge clears and waits
// - Counter cleared on resets and clock stop
// - Start 1 releases wait, 0 keeps wait
module twsc_serial_clock
    import twsc_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // Chip-level clears
    input  wire logic        clkStop,
    input  wire logic        ceReset,
    // AXI4-Lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Shift clock pin
    input  wire logic        shiftClockPinIn,
    output twsc_pin_t        shiftClockPin,
    // Data out pin
    input  wire logic        dataOutPinIn,
    output twsc_pin_t        dataOutPin,
    input  wire logic        serialOutBit,
    // Data in pin
    input  wire logic        dataInPinIn,
    output twsc_pin_t        dataInPin,
    // Status to the shift register
    output logic             serialWait,
    output logic             serialDataIn
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and state
    logic [3:0]  modeReg;          // Mode: start, out enable, clock select
    logic [7:0]  portReg;          // Direction flags and output latches
    logic        waitState;        // High while in wait
    logic [3:0]  clkCount;         // Shift clock counter, never readable
    logic [7:0]  halfCnt;          // Internal clock half-period timer
    logic        genClk;           // Internally generated clock level
    logic [2:0]  sckSync;          // Two-stage sync plus previous level
    logic [1:0]  diSync;           // Data in sync
    logic [1:0]  doSync;           // Data out pin read-back sync
    logic        awTaken;          // Write address held
    logic        wTaken;           // Write data held
    logic [3:0]  awAddr;           // Held write address
    logic [31:0] wData;            // Held write data
    logic [3:0]  wStrb;            // Held strobes
    logic        wrFire;           // Write performed this cycle
    logic        startWrite;       // Mode write touching low byte
    twsc_cksel_t ckSel;            // Decoded clock select
    logic        master;           // Internal clock selected
    logic        sckFall;          // Falling edge seen on pin
    logic        sckRise;          // Rising edge seen on pin
    logic [7:0]  halfLen;          // Half period for current code; 75 kHz needs 8 bits
    logic        clkDirOut;        // Clock pin direction flag
    logic        doDirOut;         // Data out pin direction flag
    logic        diDirOut;         // Data in pin direction flag

    assign ckSel     = twsc_cksel_t'(modeReg[`TWSC_CKSEL_HI_BIT:`TWSC_CKSEL_LO_BIT]);
    assign master    = (ckSel != TWSC_CK_EXT);
    assign clkDirOut = portReg[`TWSC_DIR_CLK_BIT];
    assign doDirOut  = portReg[`TWSC_DIR_DO_BIT];
    assign diDirOut  = portReg[`TWSC_DIR_DI_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write side: address and data taken in either order
    assign s_axi_awready = !awTaken && !s_axi_bvalid;
    assign s_axi_wready  = !wTaken && !s_axi_bvalid;
    assign s_axi_bresp   = 2'b00;
    assign wrFire        = awTaken && wTaken && !s_axi_bvalid;
    assign startWrite    = wrFire && (awAddr == `TWSC_MODE_ADDR) && wStrb[0];

    // Capture channels and issue the response
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            awTaken      <= 1'b0;
            wTaken       <= 1'b0;
            awAddr       <= 4'h0;
            wData        <= 32'h0000_0000;
            wStrb        <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awTaken <= 1'b1;
                awAddr  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wTaken <= 1'b1;
                wData  <= s_axi_wdata;
                wStrb  <= s_axi_wstrb;
            end
            if (wrFire)
            begin
                // Unmapped writes are dropped but still answered OKAY
                awTaken      <= 1'b0;
                wTaken       <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register stores; both writable fields are in the low byte
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            modeReg <= `TWSC_MODE_RESET;
            portReg <= `TWSC_PORT_RESET;
        end
        else if (wrFire && wStrb[0])
        begin
            if (awAddr == `TWSC_MODE_ADDR)
            begin
                modeReg <= wData[3:0];
            end
            else if (awAddr == `TWSC_PORT_ADDR)
            begin
                portReg <= wData[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read side; counter has no address at all
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp   = 2'b00;

    // Read data mux registered on address acceptance
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            unique case (s_axi_araddr)
                `TWSC_MODE_ADDR:
                    s_axi_rdata <= {28'h000_0000, modeReg[3] & !waitState, modeReg[2:0]};
                `TWSC_PORT_ADDR:
                    s_axi_rdata <= {24'h00_0000, portReg};
                `TWSC_PINS_ADDR:
                    s_axi_rdata <= {28'h000_0000, waitState, diSync[1], doSync[1], sckSync[1]};
                default:
                    s_axi_rdata <= 32'h0000_0000;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            sckSync <= 3'b111;
            diSync  <= 2'b00;
            doSync  <= 2'b00;
        end
        else
        begin
            sckSync <= {sckSync[1:0], shiftClockPinIn};
            diSync  <= {diSync[0], dataInPinIn};
            doSync  <= {doSync[0], dataOutPinIn};
        end
    end

    assign sckFall = sckSync[2] && !sckSync[1];
    assign sckRise = !sckSync[2] && sckSync[1];

    ////////////////////////////////////////////////////////////////////////////
    // Wait state: start bit, counter completion, forced wait
    always_ff @(posedge mclk)
    begin
        if (srst || clkStop || ceReset)
        begin
            waitState <= 1'b1;
        end
        else if (startWrite && !wData[`TWSC_TS_BIT])
        begin
            waitState <= 1'b1;
        end
        else if (!waitState && clkCount == `TWSC_BITS && sckRise)
        begin
            // Completion beats a release in the same cycle
            waitState <= 1'b1;
        end
        else if (startWrite && wData[`TWSC_TS_BIT])
        begin
            waitState <= 1'b0;
        end
    end

    // Clock counter on falling edges; held in wait
    always_ff @(posedge mclk)
    begin
        if (srst || clkStop || ceReset)
        begin
            clkCount <= 4'h0;
        end
        else if (startWrite && !wData[`TWSC_TS_BIT])
        begin
            clkCount <= 4'h0;
        end
        else if (waitState)
        begin
            clkCount <= clkCount;
        end
        else if (clkCount == `TWSC_BITS)
        begin
            if (sckRise)
            begin
                clkCount <= 4'h0;
            end
        end
        else if (sckFall)
        begin
            clkCount <= clkCount + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Internal clock generator
    always_comb
    begin
        unique case (ckSel)
            TWSC_CK_F75:  halfLen = 8'(`TWSC_HALF1 - 1);
            TWSC_CK_F150: halfLen = 8'(`TWSC_HALF2 - 1);
            TWSC_CK_F450: halfLen = 8'(`TWSC_HALF3 - 1);
            TWSC_CK_EXT:  halfLen = 8'h00;
        endcase
    end

    // Runs only while released; a release always starts from high
    always_ff @(posedge mclk)
    begin
        if (srst || waitState || !master)
        begin
            genClk  <= 1'b1;
            halfCnt <= 8'h00;
        end
        else if (clkCount == `TWSC_BITS && genClk)
        begin
            // Eight clocks sent: idle high until wait lands
            halfCnt <= 8'h00;
        end
        else if (halfCnt >= halfLen)
        begin
            genClk  <= !genClk;
            halfCnt <= 8'h00;
        end
        else
        begin
            halfCnt <= halfCnt + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin roles from mode and direction flags
    always_comb
    begin
        // Clock pin
        if (!clkDirOut)
        begin
            shiftClockPin = '{dout: 1'b1, oen_n: 1'b1};
        end
        else if (master)
        begin
            // Generator reset lags wait by a cycle, so wait forces high here
            shiftClockPin = '{dout: genClk || waitState, oen_n: 1'b0};
        end
        else
        begin
            shiftClockPin = '{dout: portReg[`TWSC_LAT_CLK_BIT], oen_n: 1'b0};
        end
        // Data out pin
        if (doDirOut && modeReg[`TWSC_SOEN_BIT])
        begin
            dataOutPin = '{dout: serialOutBit, oen_n: 1'b0};
        end
        else if (doDirOut)
        begin
            dataOutPin = '{dout: portReg[`TWSC_LAT_DO_BIT], oen_n: 1'b0};
        end
        else
        begin
            dataOutPin = '{dout: 1'b0, oen_n: 1'b1};
        end
        // Data in pin drives low as a plain output
        dataInPin = '{dout: 1'b0, oen_n: !diDirOut};
    end

    assign serialWait   = waitState;
    assign serialDataIn = diSync[1] & !diDirOut;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    a_count_holds_wait: assert property (@(posedge mclk) disable iff (srst)
        waitState && $past(waitState) && !$past(startWrite) |-> $stable(clkCount))
        else $error("counter moved during wait");
    a_count_max_eight: assert property (@(posedge mclk) disable iff (srst)
        clkCount <= `TWSC_BITS)
        else $error("counter passed eight");
    a_eight_to_wait: assert property (@(posedge mclk) disable iff (srst)
        !waitState && clkCount == `TWSC_BITS && sckRise && !startWrite && !clkStop && !ceReset
        |=> waitState && clkCount == 4'h0)
        else $error("no wait after eighth clock");
    a_force_clears: assert property (@(posedge mclk) disable iff (srst)
        startWrite && !wData[`TWSC_TS_BIT] |=> waitState && clkCount == 4'h0)
        else $error("forced wait did not clear");
    a_release_works: assert property (@(posedge mclk) disable iff (srst)
        startWrite && wData[`TWSC_TS_BIT] && !clkStop && !ceReset
        && !(!waitState && clkCount == `TWSC_BITS && sckRise) |=> !waitState)
        else $error("release ignored");
    a_wait_clock_high: assert property (@(posedge mclk) disable iff (srst)
        waitState && master && clkDirOut |-> shiftClockPin.dout && !shiftClockPin.oen_n)
        else $error("clock not high in wait");
    a_fall_counts: assert property (@(posedge mclk) disable iff (srst)
        !waitState && sckFall && clkCount < `TWSC_BITS && !startWrite && !clkStop && !ceReset
        |=> clkCount == $past(clkCount) + 4'h1)
        else $error("falling edge not counted");
    a_reset_clears: assert property (@(posedge mclk) disable iff (srst)
        clkStop || ceReset |=> clkCount == 4'h0 && waitState)
        else $error("clear did not reset counter");
    a_input_released: assert property (@(posedge mclk) disable iff (srst)
        !clkDirOut |-> shiftClockPin.oen_n)
        else $error("clock pin driven as input");
    c_full_transfer: cover property (@(posedge mclk) disable iff (srst)
        !waitState && clkCount == `TWSC_BITS ##1 waitState);
    c_forced_busy: cover property (@(posedge mclk) disable iff (srst)
        !waitState && clkCount != 4'h0 && startWrite && !wData[`TWSC_TS_BIT]);
    c_rerelease: cover property (@(posedge mclk) disable iff (srst)
        !waitState && startWrite && wData[`TWSC_TS_BIT]);

endmodule : twsc_serial_clock

// file: sim/twsc_link_partner.sv
`timescale 1ns/1ps
// Far-side serial master: makes the link clock only inside frames
module twsc_link_partner
(
    // Frame request
    input  wire logic       go,
    input  wire logic [3:0] pulses,
    // Link lines
    output logic            sck,
    output logic            sdo,
    output logic            busy
);
    // Clock idles high; idle data toggles so a stale level never looks valid
    initial
    begin
        sck  = 1'h1;
        sdo  = 1'h0;
        busy = 1'h0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Frame of pulses at 400 ns; odd start offset keeps phase unrelated to mclk
    always @(posedge go)
    begin
        busy = 1'h1;
        #37;
        repeat (pulses)
        begin
            sck = 1'h0;
            sdo = ~sdo;
            #200;
            sck = 1'h1;
            #200;
        end
        busy = 1'h0;
    end
    // Idle pattern on the data line
    always #50
    begin
        if (!busy)
            sdo = ~sdo;
    end
endmodule : twsc_link_partner

// file: sim/twsc_serial_clock_tb_top.sv
`timescale 1ns/1ps
`include "twsc_defines.svh"
module twsc_serial_clock_tb_top
    import twsc_pkg::*;
;
    // Static pin rows and frame rows
    typedef struct {logic [3:0] mode; logic [7:0] port; logic sob;
        twsc_pin_t sck; twsc_pin_t dout; logic diOen;} twsc_pin_row_t;
    typedef struct {logic [3:0] mode; logic [7:0] port; int half;} twsc_frame_row_t;
    localparam int TIMEOUT_CYCLES = 30000; // Whole run needs about 11000
    logic mclk, srst, clkStop, ceReset, go, sckPrev, sob;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic [3:0]  awaddr, araddr, pulses;
    logic [31:0] wdata, rd;
    logic awready, wready, bvalid, arready, rvalid, serialWait, serialDataIn;
    logic [31:0] rdata;
    logic extSck, extSdo, extBusy, sckWire;
    twsc_pin_t   shiftClockPin, dataOutPin, dataInPin;
    int num_errors, num_checks, cycles, falls, f0;
    // Wire levels: the device wins where it drives, else the far side
    assign sckWire = shiftClockPin.oen_n ? extSck : shiftClockPin.dout;
    twsc_serial_clock twsc_serial_clock_inst (.mclk(mclk), .srst(srst),
        .clkStop(clkStop), .ceReset(ceReset), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .shiftClockPinIn(sckWire),
        .shiftClockPin(shiftClockPin),
        .dataOutPinIn(dataOutPin.oen_n ? ~extSdo : dataOutPin.dout),
        .dataOutPin(dataOutPin), .serialOutBit(sob),
        .dataInPinIn(dataInPin.oen_n ? extSdo : dataInPin.dout),
        .dataInPin(dataInPin), .serialWait(serialWait), .serialDataIn(serialDataIn));
    twsc_link_partner twsc_link_partner_inst (.go(go), .pulses(pulses), .sck(extSck),
        .sdo(extSdo), .busy(extBusy));
    ////////////////////////////////////////////////////////////////////////////
    // Clock
    initial
    begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end
    // Falling edges seen on the pin wire, plus timeout counter
    always @(posedge mclk)
    begin
        sckPrev <= sckWire;
        if (sckPrev === 1'h1 && sckWire === 1'h0)
            falls <= falls + 1;
        cycles <= cycles + 1;
        if (cycles == TIMEOUT_CYCLES)
        begin
            num_errors++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'h1)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check
    // Master write: both channels offered, each dropped when taken
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        do
        begin
            @(posedge mclk);
            if (awvalid && awready)
                awvalid <= 1'h0;
            if (wvalid && wready)
                wvalid <= 1'h0;
        end
        while (bvalid !== 1'h1);
        bready <= 1'h0;
        // One edge between calls so bready is never set twice at once
        @(posedge mclk);
    endtask : axi_write
    task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do
        begin
            @(posedge mclk);
            if (arvalid && arready)
                arvalid <= 1'h0;
            d = rdata;
        end
        while (rvalid !== 1'h1);
        rready <= 1'h0;
        @(posedge mclk);
    endtask : axi_read
    // One transfer; poke 1 rewrites mode, 2 clock stop, 3 chip-enable reset
    task automatic frame(input logic [3:0] mode, input logic [7:0] port, input int half,
        input int poke, input int pokeAt, input logic [3:0] pokeMode);
        int t0;
        int n;
        axi_write(`TWSC_PORT_ADDR, {24'h00_0000, port});
        axi_write(`TWSC_MODE_ADDR, {28'h000_0000, mode});
        f0 = falls;
        t0 = cycles;
        n = 0;
        if (mode[1:0] == 2'h0)
            go <= 1'h1;
        if (poke != 0)
        begin
            while (falls - f0 < pokeAt && n < 5000)
            begin
                @(posedge mclk);
                n++;
            end
            if (poke == 1)
                axi_write(`TWSC_MODE_ADDR, {28'h000_0000, pokeMode});
            else
            begin
                clkStop <= (poke == 2);
                ceReset <= (poke == 3);
                @(posedge mclk);
                clkStop <= 1'h0;
                ceReset <= 1'h0;
            end
            if (!pokeMode[3])
            begin
                @(negedge mclk);
                check(serialWait === 1'h1 && shiftClockPin === 2'h2, "forced wait");
                @(posedge mclk);
                return;
            end
        end
        while (serialWait !== 1'h1 && n < 40 * half + 200)
        begin
            @(posedge mclk);
            n++;
            go <= 1'h0;
        end
        @(negedge mclk);
        check(falls - f0 == 8, "shift clock count");
        check(cycles - t0 >= 16 * half - 6 && cycles - t0 <= 16 * half + 6, "frame length");
        check(shiftClockPin.oen_n === 1'h1 || shiftClockPin.dout === 1'h1, "idle high");
        @(posedge mclk);
    endtask : frame
    task automatic end_test(input string name);
        $display("Test %s done, errors so far %0d", name, num_errors);
    endtask : end_test
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////////
    // Pin rows: mode, port, serial out bit, clock pin, data-out pin, data-in oen_n
    twsc_pin_row_t pinRows [13] = '{
        '{4'h0, 8'h00, 1'h0, 2'h1, 2'h1, 1'h1}, '{4'h0, 8'h01, 1'h0, 2'h0, 2'h1, 1'h1},
        '{4'h0, 8'h11, 1'h0, 2'h2, 2'h1, 1'h1}, '{4'h1, 8'h10, 1'h0, 2'h1, 2'h1, 1'h1},
        '{4'h1, 8'h01, 1'h0, 2'h2, 2'h1, 1'h1}, '{4'h5, 8'h13, 1'h1, 2'h2, 2'h2, 1'h1},
        '{4'h5, 8'h13, 1'h0, 2'h2, 2'h0, 1'h1}, '{4'h1, 8'h33, 1'h0, 2'h2, 2'h2, 1'h1},
        '{4'h5, 8'h11, 1'h1, 2'h2, 2'h1, 1'h1}, '{4'h1, 8'h15, 1'h0, 2'h2, 2'h1, 1'h0},
        '{4'h8, 8'h00, 1'h0, 2'h1, 2'h1, 1'h1}, '{4'h8, 8'h11, 1'h0, 2'h2, 2'h1, 1'h1},
        '{4'h9, 8'h10, 1'h0, 2'h1, 2'h1, 1'h1}};
    // Each row sets the clock select and releases in one write; the last row selects the external clock
    twsc_frame_row_t frRows [4] = '{'{4'h9, 8'h11, `TWSC_HALF1},
        '{4'hA, 8'h11, `TWSC_HALF2}, '{4'hB, 8'h11, `TWSC_HALF3}, '{4'h8, 8'h00, 4}};
    initial
    begin
        {srst, clkStop, ceReset, go, sob, awvalid, wvalid, bready, arvalid, rready} = 10'h200;
        {awaddr, araddr, wdata, pulses} = {40'h00_0000_0000, 4'h8};
        {num_errors, num_checks, cycles, falls, sckPrev} = '0;
        repeat (4) @(posedge mclk);
        srst <= 1'h0;
        @(posedge mclk);
        axi_read(`TWSC_MODE_ADDR, rd);
        check(rd === 32'h0000_0001, "mode reset");
        axi_read(`TWSC_PORT_ADDR, rd);
        check(rd === 32'h0000_0011, "port reset");
        axi_read(`TWSC_PINS_ADDR, rd);
        check((rd & 32'h0000_0009) === 32'h0000_0009, "wait and pin high");
        axi_read(`TWSC_START_ADDR, rd);
        check(rd === 32'h0000_0000, "counter hidden");
        end_test("reset");
        foreach (pinRows[i])
        begin
            sob <= pinRows[i].sob;
            axi_write(`TWSC_PORT_ADDR, {24'h00_0000, pinRows[i].port});
            axi_write(`TWSC_MODE_ADDR, {28'h000_0000, pinRows[i].mode});
            @(negedge mclk);
            check(pinRows[i].sck.oen_n ? shiftClockPin.oen_n === 1'h1 : shiftClockPin === pinRows[i].sck, "clock pin");
            check(pinRows[i].dout.oen_n ? dataOutPin.oen_n === 1'h1 : dataOutPin === pinRows[i].dout, "data-out pin");
            check(dataInPin.oen_n === pinRows[i].diOen && (pinRows[i].diOen || serialDataIn === 1'h0), "data-in pin");
            @(posedge mclk);
        end
        axi_write(`TWSC_MODE_ADDR, 32'h0000_0001);
        end_test("pin table");
        foreach (frRows[i])
            frame(frRows[i].mode, frRows[i].port, frRows[i].half, 0, 0, 4'h0);
        end_test("frequencies");
        frame(4'h9, 8'h11, `TWSC_HALF1, 1, 3, 4'h1);
        frame(4'h9, 8'h11, `TWSC_HALF1, 0, 0, 4'h0);
        frame(4'hB, 8'h11, `TWSC_HALF3, 1, 2, 4'hB);
        frame(4'hB, 8'h11, `TWSC_HALF3, 2, 4, 4'h1);
        frame(4'hB, 8'h11, `TWSC_HALF3, 0, 0, 4'h0);
        frame(4'hB, 8'h11, `TWSC_HALF3, 3, 4, 4'h1);
        frame(4'hB, 8'h11, `TWSC_HALF3, 0, 0, 4'h0);
        end_test("aborts");
        axi_write(`TWSC_MODE_ADDR, 32'h0000_0001);
        f0 = falls;
        repeat (300) @(posedge mclk);
        @(negedge mclk);
        check(falls == f0 && shiftClockPin === 2'h2 && serialWait === 1'h1, "wait in wait");
        @(posedge mclk);
        axi_write(`TWSC_PORT_ADDR, 32'h0000_0000);
        axi_write(`TWSC_MODE_ADDR, 32'h0000_0000);
        pulses <= 4'h5;
        go <= 1'h1;
        repeat (80) @(posedge mclk);
        go <= 1'h0;
        pulses <= 4'h8;
        @(negedge mclk);
        check(serialWait === 1'h1 && extBusy === 1'h0, "no release by clock");
        @(posedge mclk);
        frame(4'h8, 8'h00, 4, 0, 0, 4'h0);
        end_test("hold in wait");
        // Reset in the middle of a running transfer
        axi_write(`TWSC_PORT_ADDR, 32'h0000_0011);
        axi_write(`TWSC_MODE_ADDR, 32'h0000_000B);
        repeat (60) @(posedge mclk);
        srst <= 1'h1;
        @(posedge mclk);
        srst <= 1'h0;
        @(negedge mclk);
        check(serialWait === 1'h1 && shiftClockPin === 2'h2, "reset mid-frame");
        @(posedge mclk);
        axi_read(`TWSC_MODE_ADDR, rd);
        check(rd === 32'h0000_0001, "mode after reset");
        frame(4'h9, 8'h11, `TWSC_HALF1, 0, 0, 4'h0);
        end_test("mid-run reset");
        final_report();
    end
endmodule : twsc_serial_clock_tb_top
